// >>> core/fpcr_pkg.sv
// Package with the constants and types of the flash protection and configuration register block.
package fpcr_pkg;

   // ********************************************************************
   // Command codes seen on the serial link.
   // ********************************************************************
   localparam logic [7:0] CMD_SET_READ_PARAMS_PERSISTENT = 8'h65; // Non-volatile read-parameter set.
   localparam logic [7:0] CMD_SET_READ_PARAMS_TEMPORARY_A = 8'hc0; // Volatile read-parameter set.
   localparam logic [7:0] CMD_SET_READ_PARAMS_TEMPORARY_B = 8'h63; // Alternate volatile set.
   localparam logic [7:0] CMD_WRITE_FUNCTION = 8'h42; // Function register write.
   localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06; // Sets the write enable latch.
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h04; // Clears the write enable latch.

   // ********************************************************************
   // Function register field positions and reset values.
   // ********************************************************************
   localparam int FN_RESET_DISABLE_BIT = 0; // One-time dedicated reset disable.
   localparam int FN_PROGRAM_PAUSED_BIT = 2; // Program suspend flag.
   localparam int FN_ERASE_PAUSED_BIT = 3; // Erase suspend flag.
   localparam int FN_ROW_LOCK_LSB = 4; // Lowest information row lock.
   localparam logic [7:0] FN_OTP_MASK = 8'hf1; // Bits that only ever go from 0 to 1.
   localparam logic [7:0] FN_RESET_VALUE = 8'h00; // Factory value apart from bit 0.

   // ********************************************************************
   // Read-parameter register field positions and reset value.
   // ********************************************************************
   localparam int RP_PIN_ROLE_BIT = 7; // Shared pin role select.
   localparam int RP_DUMMY_MSB = 6; // Dummy-cycle field top bit.
   localparam int RP_DUMMY_LSB = 3; // Dummy-cycle field bottom bit.
   localparam int RP_WRAP_ENABLE_BIT = 2; // Wrapped burst enable.
   localparam int RP_BURST_MSB = 1; // Burst length code top bit.
   localparam int RP_BURST_LSB = 0; // Burst length code bottom bit.
   localparam logic [7:0] RP_RESET_VALUE = 8'h00; // Factory value of both copies.

   // ********************************************************************
   // Protection and timing figures.
   // ********************************************************************
   localparam logic [6:0] BLOCK_COUNT = 7'h40; // Number of 64-Kbyte blocks.
   localparam logic [5:0] BLOCK_LAST = 6'h3f; // Index of the top block.
   localparam logic [6:0] WRAP_BASE_BYTES = 7'h08; // Shortest wrap length.
   localparam logic [3:0] DUMMY_FAST_SPI = 4'h8; // Default for single-line fast read.
   localparam logic [3:0] DUMMY_FAST_QPI = 4'h6; // Default for fast read in quad command mode.
   localparam logic [3:0] DUMMY_DUAL_OUT = 4'h8; // Default for dual output read.
   localparam logic [3:0] DUMMY_DUAL_IO = 4'h4; // Default for dual I/O read.
   localparam logic [3:0] DUMMY_QUAD_OUT = 4'h8; // Default for quad output read.
   localparam logic [3:0] DUMMY_QUAD_IO = 4'h6; // Default for quad I/O read.
   localparam logic [4:0] LINK_BITS_CMD = 5'h07; // Bit count at the last command bit.
   localparam logic [4:0] LINK_BITS_DATA = 5'h0f; // Bit count at the last data bit.
   localparam logic [4:0] LINK_BITS_DONE = 5'h10; // Counter stops here.

   // Read command families that pick a default dummy count.
   typedef enum logic [2:0] {
      FPCR_RD_FAST_SPI,
      FPCR_RD_FAST_QPI,
      FPCR_RD_DUAL_OUT,
      FPCR_RD_DUAL_IO,
      FPCR_RD_QUAD_OUT,
      FPCR_RD_QUAD_IO
   } fpcr_read_kind_e;

endpackage

// >>> core/fpcr_top.sv
// Flash protection decode, function register and read-parameter register logic.
`timescale 1ns/1ps
// Summary of operation
// [R1] Low half: protection grows down from block 63.
// [R2] High half: protection grows up from block 0.
// [R3] Reset disable bit writable only while zero.
// [R4] Disable set: dedicated pin ignored, shared pin resets.
// [R5] Program suspend flag set on suspend, cleared resume.
// [R6] Erase suspend flag set on suspend, cleared resume.
// [R7] Row lock bits block programming of rows.
// [R8] One-time bits never return to zero.
// [R9] Volatile copy loaded from non-volatile at power-up.
// [R10] Bit 7 picks hold or reset role.
// [R11] Quad enable or quad mode makes pin data3.
// [R12] Enabled dedicated reset forces hold role.
// [R13] Nonzero dummy field sets dummy count directly.
// [R14] Bit 2 enables wrap, bits 1-0 length.
// [R15] Persistent and temporary set commands honoured accordingly.
// [R16] Zero dummy field selects per-command default count.
// [R17] Length code picks 8, 16, 32, 64.
// [R18] Wrap off reads whole array, on wraps.
// [R19] Host unlocks writes before non-volatile writes.
// [R20] Active behaviour follows the volatile read-parameter copy.
module fpcr_top
   import fpcr_pkg::*;
#(
   parameter logic RESET_DISABLE_DEFAULT = 1'b0, // Part-dependent power-up value of the reset disable.
   parameter logic HAS_DEDICATED_RESET = 1'b1 // Part has a dedicated reset pin.
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic link_sck,
   input wire logic link_cs_n,
   input wire logic link_si,
   input wire logic [3:0] block_guard,
   input wire logic quad_lines_enable,
   input wire logic quad_command_mode,
   input wire logic program_busy,
   input wire logic erase_busy,
   input wire logic suspend_cmd,
   input wire logic resume_cmd,
   input wire logic info_prog_req,
   input wire logic [1:0] info_row_sel,
   input wire fpcr_read_kind_e read_kind,
   input wire logic dedicated_reset_n,
   input wire logic shared_pin_n,
   output logic [7:0] function_config,
   output logic [7:0] read_parameters,
   output logic [7:0] read_parameters_nv,
   output logic write_unlocked,
   output logic protect_any,
   output logic [5:0] protect_first,
   output logic [5:0] protect_last,
   output logic info_prog_ok,
   output logic shared_pin_is_reset,
   output logic shared_pin_is_io3,
   output logic device_reset_req,
   output logic [3:0] dummy_cycles,
   output logic wrap_on,
   output logic [6:0] wrap_len
);

   // ********************************************************************
   // Link side, clocked by the host serial clock.
   // ********************************************************************
   logic [4:0] bit_cnt_q; // Bits seen in the current frame.
   logic [6:0] shift_q; // Serial shift register.
   logic [7:0] cmd_q; // Command byte of the last frame.
   logic [7:0] data_q; // Data byte of the last frame.
   logic cmd_tog_q; // Flips when a command byte is complete.
   logic data_tog_q; // Flips when a data byte is complete.

   // The serial clock stops between frames, so chip select itself clears the bit counter.
   always_ff @(posedge link_sck or posedge link_cs_n)
   begin
      if (link_cs_n)
         bit_cnt_q <= 5'h00;
      else if (bit_cnt_q != LINK_BITS_DONE)
         bit_cnt_q <= bit_cnt_q + 5'h01;
   end

   // Shift data in on the rising serial clock edge.
   always_ff @(posedge link_sck)
   begin
      shift_q <= {shift_q[5:0], link_si};
   end

   // Capture bytes and flip the event toggles; the bytes hold until the next frame.
   // The core reset clears these asynchronously because the link clock is idle while it stands.
   always_ff @(posedge link_sck or posedge reset)
   begin
      if (reset)
      begin
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         cmd_tog_q <= 1'b0;
         data_tog_q <= 1'b0;
      end
      else if (!link_cs_n && bit_cnt_q == LINK_BITS_CMD)
      begin
         cmd_q <= {shift_q, link_si};
         cmd_tog_q <= ~cmd_tog_q;
      end
      else if (!link_cs_n && bit_cnt_q == LINK_BITS_DATA)
      begin
         data_q <= {shift_q, link_si};
         data_tog_q <= ~data_tog_q;
      end
   end

   // ********************************************************************
   // Crossing into the core clock domain.
   // ********************************************************************
   logic [2:0] cmd_sync_q; // Toggle synchroniser plus edge stage.
   logic [2:0] data_sync_q; // Toggle synchroniser plus edge stage.
   logic [1:0] ded_sync_q; // Dedicated reset pin synchroniser.
   logic [1:0] shr_sync_q; // Shared pin synchroniser.

   // Only the second and third stages feed logic.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cmd_sync_q <= 3'h0;
         data_sync_q <= 3'h0;
         ded_sync_q <= 2'h3;
         shr_sync_q <= 2'h3;
      end
      else
      begin
         cmd_sync_q <= {cmd_sync_q[1:0], cmd_tog_q};
         data_sync_q <= {data_sync_q[1:0], data_tog_q};
         ded_sync_q <= {ded_sync_q[0], dedicated_reset_n};
         shr_sync_q <= {shr_sync_q[0], shared_pin_n};
      end
   end

   wire cmd_event = cmd_sync_q[2] ^ cmd_sync_q[1]; // Command byte arrived.
   wire data_event = data_sync_q[2] ^ data_sync_q[1]; // Data byte arrived.

   // ********************************************************************
   // Command decode.
   // ********************************************************************
   logic wel_q; // Write enable latch.
   logic load_q; // High for the power-up load cycle.
   logic [7:0] fn_q; // Function register.
   logic [7:0] rp_nv_q; // Persistent read-parameter copy.
   logic [7:0] rp_vol_q; // Working read-parameter copy.

   // Command and data bytes are stable here since the host cannot start a new frame this soon.
   wire wr_unlock = cmd_event && cmd_q == CMD_WRITE_UNLOCK;
   wire wr_lock = cmd_event && cmd_q == CMD_WRITE_LOCK;
   wire wr_rp_nv = data_event && cmd_q == CMD_SET_READ_PARAMS_PERSISTENT && wel_q; // [R15] [R19]
   wire wr_rp_vol = data_event && (cmd_q == CMD_SET_READ_PARAMS_TEMPORARY_A ||
                                   cmd_q == CMD_SET_READ_PARAMS_TEMPORARY_B); // [R15]
   wire wr_fn = data_event && cmd_q == CMD_WRITE_FUNCTION && wel_q; // [R19]

   // Unlock latch; any completed non-volatile write drops it again.
   wire wel_d = wr_unlock | (wel_q & ~wr_lock & ~wr_rp_nv & ~wr_fn);

   // ********************************************************************
   // Function register.
   // ********************************************************************
   // One-time bits only accumulate ones, so a bit at one ignores later writes.
   wire [7:0] fn_otp_d = fn_q | (data_q & FN_OTP_MASK & {8{wr_fn}}); // [R3] [R8]
   // Suspend flags: the set wins over a resume in the same cycle.
   wire prog_pause_set = suspend_cmd & program_busy; // [R5]
   wire erase_pause_set = suspend_cmd & erase_busy & ~program_busy; // [R6]
   wire prog_pause_d = prog_pause_set | (fn_q[FN_PROGRAM_PAUSED_BIT] & ~resume_cmd); // [R5]
   wire erase_pause_d = erase_pause_set | (fn_q[FN_ERASE_PAUSED_BIT] & ~resume_cmd); // [R6]
   wire [7:0] fn_d = {fn_otp_d[7:4], erase_pause_d, prog_pause_d, 1'b0, fn_otp_d[0]};

   // ********************************************************************
   // Read-parameter register pair.
   // ********************************************************************
   // The persistent set updates both copies so that it also takes effect at once.
   wire [7:0] rp_nv_d = wr_rp_nv ? data_q : rp_nv_q; // [R15]
   wire [7:0] rp_vol_d = load_q ? rp_nv_q : (wr_rp_nv | wr_rp_vol) ? data_q : rp_vol_q; // [R9] [R15]

   // Register state; reset stands for power-up with factory cell values.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wel_q <= 1'b0;
         load_q <= 1'b1;
         fn_q <= FN_RESET_VALUE | {7'h00, RESET_DISABLE_DEFAULT}; // [R3]
         rp_nv_q <= RP_RESET_VALUE; // [R14]
         rp_vol_q <= RP_RESET_VALUE;
      end
      else
      begin
         wel_q <= wel_d;
         load_q <= 1'b0;
         fn_q <= fn_d;
         rp_nv_q <= rp_nv_d;
         rp_vol_q <= rp_vol_d;
      end
   end

   // ********************************************************************
   // Block protection decode.
   // ********************************************************************
   wire [2:0] bp_low = block_guard[2:0];
   wire bp_none = block_guard[3] ? (bp_low == 3'h7) : (bp_low == 3'h0);
   wire bp_all = block_guard[3] ? (bp_low == 3'h0) : (bp_low == 3'h7);
   // Span sizes of the partial ranges: 1 to 32 blocks.
   wire [6:0] span_down = BLOCK_COUNT >> (3'h7 - bp_low); // [R1]
   wire [6:0] span_up = BLOCK_COUNT >> bp_low; // [R2]
   wire [6:0] first_down = BLOCK_COUNT - span_down; // [R1]
   wire [6:0] last_up = span_up - 7'h01; // [R2]
   wire [5:0] prot_first_d = (bp_all || block_guard[3]) ? 6'h00 : first_down[5:0]; // [R1] [R2]
   wire [5:0] prot_last_d = (bp_all || !block_guard[3]) ? BLOCK_LAST : last_up[5:0]; // [R1] [R2]

   // ********************************************************************
   // Pin roles, dummy count and wrap, all from the working copy.
   // ********************************************************************
   wire reset_disabled = fn_q[FN_RESET_DISABLE_BIT];
   wire io3_d = quad_lines_enable | quad_command_mode; // [R11]
   // An enabled dedicated reset pin forces the hold role on the shared pin.
   wire role_free = ~HAS_DEDICATED_RESET | reset_disabled; // [R12]
   wire shr_reset_d = ~io3_d & role_free & rp_vol_q[RP_PIN_ROLE_BIT]; // [R10] [R20]
   // The dedicated pin is ignored once disabled; the shared pin in reset role then resets.
   wire ded_ok = HAS_DEDICATED_RESET & ~reset_disabled; // [R4]
   wire dev_rst_d = (ded_ok & ~ded_sync_q[1]) | (shr_reset_d & ~shr_sync_q[1]); // [R4]

   wire [3:0] dummy_field = rp_vol_q[RP_DUMMY_MSB:RP_DUMMY_LSB]; // [R20]
   logic [3:0] dummy_default;
   // Per-family default count for a zero field.
   always_comb
   begin
      unique case (read_kind)
         FPCR_RD_FAST_SPI: dummy_default = DUMMY_FAST_SPI; // [R16]
         FPCR_RD_FAST_QPI: dummy_default = DUMMY_FAST_QPI;
         FPCR_RD_DUAL_OUT: dummy_default = DUMMY_DUAL_OUT;
         FPCR_RD_DUAL_IO: dummy_default = DUMMY_DUAL_IO;
         FPCR_RD_QUAD_OUT: dummy_default = DUMMY_QUAD_OUT;
         FPCR_RD_QUAD_IO: dummy_default = DUMMY_QUAD_IO;
         default: dummy_default = DUMMY_FAST_SPI; // Unused code falls back to the slowest case.
      endcase
   end
   wire [3:0] dummy_d = (dummy_field != 4'h0) ? dummy_field : dummy_default; // [R13] [R16]
   wire wrap_d = rp_vol_q[RP_WRAP_ENABLE_BIT]; // [R14] [R18]
   // Wrap length doubles per code step; zero means the whole array.
   wire [6:0] wrap_len_d = wrap_d ? (WRAP_BASE_BYTES << rp_vol_q[RP_BURST_MSB:RP_BURST_LSB]) : 7'h00; // [R17] [R18]

   // Registered decode outputs.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         protect_any <= 1'b0;
         protect_first <= 6'h00;
         protect_last <= 6'h00;
         shared_pin_is_reset <= 1'b0;
         shared_pin_is_io3 <= 1'b0;
         device_reset_req <= 1'b0;
         dummy_cycles <= DUMMY_FAST_SPI;
         wrap_on <= 1'b0;
         wrap_len <= 7'h00;
      end
      else
      begin
         protect_any <= ~bp_none;
         protect_first <= bp_none ? 6'h00 : prot_first_d;
         protect_last <= bp_none ? 6'h00 : prot_last_d;
         shared_pin_is_reset <= shr_reset_d;
         shared_pin_is_io3 <= io3_d;
         device_reset_req <= dev_rst_d;
         dummy_cycles <= dummy_d;
         wrap_on <= wrap_d;
         wrap_len <= wrap_len_d;
      end
   end

   // Locked rows refuse programming; the answer is a handshake and so combinational.
   assign info_prog_ok = info_prog_req & ~fn_q[FN_ROW_LOCK_LSB + int'(info_row_sel)]; // [R7]
   assign function_config = fn_q;
   assign read_parameters = rp_vol_q;
   assign read_parameters_nv = rp_nv_q;
   assign write_unlocked = wel_q;

   // ********************************************************************
   // Assertions and covers.
   // ********************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Most outputs are registered, so the checks look one clock after their trigger.

   AST_PROT_DOWN_4: assert property (block_guard == 4'h3 |=> protect_first == 6'h3c && protect_last == 6'h3f) // [R1]
      else $error("low half code 3 not blocks 60 to 63");
   AST_PROT_NONE: assert property (block_guard == 4'h0 |=> !protect_any) // [R1]
      else $error("code 0 still protects");
   AST_PROT_UP_32: assert property (block_guard == 4'h9 |=> protect_first == 6'h00 && protect_last == 6'h1f) // [R2]
      else $error("high half code 1 not blocks 0 to 31");
   AST_RESET_DIS_STICKY: assert property (fn_q[0] |=> fn_q[0]) // [R3]
      else $error("reset disable bit returned to zero");
   AST_OTP_STICKY: assert property (##1 (fn_q[7:4] & $past(fn_q[7:4])) == $past(fn_q[7:4])) // [R8]
      else $error("row lock bit cleared");
   AST_DED_IGNORED: assert property (fn_q[0] && !shared_pin_is_reset ##1 !shared_pin_is_reset |-> !device_reset_req) // [R4]
      else $error("dedicated reset acted while disabled");
   AST_PROGRAM_PAUSED_FLAG_SET: assert property (suspend_cmd && program_busy |=> // [R5]
      fn_q[2] && fn_q[3] == ($past(fn_q[3]) && !$past(resume_cmd)))
      else $error("program suspend flag not set");
   AST_ERASE_PAUSED_FLAG_SET: assert property (suspend_cmd && erase_busy && !program_busy |=> fn_q[3]) // [R6]
      else $error("erase suspend flag not set");
   AST_RESUME_CLR: assert property (resume_cmd && !suspend_cmd |=> !fn_q[2] && !fn_q[3]) // [R5] [R6]
      else $error("suspend flag kept after resume");
   AST_ROW_LOCK: assert property (info_prog_req && fn_q[4 + int'(info_row_sel)] |-> !info_prog_ok) // [R7]
      else $error("locked row accepted programming");
   AST_POWER_LOAD: assert property (load_q |=> rp_vol_q == $past(rp_nv_q)) // [R9]
      else $error("volatile copy not loaded at power-up");
   AST_ROLE_SEL: assert property (!io3_d && role_free |=> shared_pin_is_reset == $past(rp_vol_q[7])) // [R10]
      else $error("shared pin role does not follow bit 7");
   AST_IO3: assert property (quad_lines_enable || quad_command_mode |=> shared_pin_is_io3 && !shared_pin_is_reset) // [R11]
      else $error("quad mode left shared pin in control role");
   AST_HOLD_FORCED: assert property (HAS_DEDICATED_RESET && !fn_q[0] |=> !shared_pin_is_reset) // [R12]
      else $error("reset role granted with dedicated reset enabled");
   AST_DUMMY: assert property (rp_vol_q[6:3] != 4'h0 |=> dummy_cycles == $past(rp_vol_q[6:3])) // [R13]
      else $error("dummy count differs from field");
   AST_DUMMY_DEFAULT: assert property (rp_vol_q[6:3] == 4'h0 && read_kind == FPCR_RD_DUAL_IO |=> dummy_cycles == 4'h4) // [R16]
      else $error("dual io default not 4");
   AST_WRAP_64: assert property (rp_vol_q[2:0] == 3'h7 |=> wrap_on && wrap_len == 7'h40) // [R14] [R17]
      else $error("wrap length code 3 not 64 bytes");
   AST_WRAP_OFF: assert property (!rp_vol_q[2] |=> !wrap_on && wrap_len == 7'h00) // [R18]
      else $error("wrap active while disabled");
   AST_VOL_SET: assert property (wr_rp_vol |=> rp_vol_q == $past(data_q) && $stable(rp_nv_q)) // [R15] [R20]
      else $error("temporary set misapplied");
   AST_NV_NEEDS_UNLOCK: assert property (!wel_q |=> $stable(rp_nv_q)) // [R19]
      else $error("persistent copy changed while locked");
   AST_NV_SET: assert property (wr_rp_nv |=> rp_nv_q == $past(data_q) && rp_vol_q == $past(data_q)) // [R15]
      else $error("persistent set did not reach both copies");
   AST_UNLOCK_SPENT: assert property (wr_rp_nv || wr_fn |=> !wel_q) // [R15]
      else $error("write unlock kept after a persistent write");

   // The covers show that the main scenarios were really reached.

   COV_NV_SET: cover property (wr_rp_nv ##1 rp_nv_q == rp_vol_q);
   COV_SUSPEND_RESUME: cover property (fn_q[2] ##[1:50] !fn_q[2]);
   COV_SHARED_RESET: cover property (device_reset_req && shared_pin_is_reset);
   COV_FN_WRITE: cover property (wr_fn ##1 fn_q[7:4] != 4'h0);
   COV_WRAP_OFF: cover property (wrap_on ##1 !wrap_on);

endmodule

// >>> testbench/fpcr_host_model.sv
// Host serial controller model that sends register frames to the block.
`timescale 1ns/1ps
module fpcr_host_model
   import fpcr_pkg::*;
(
   output logic sck,
   output logic cs_n,
   output logic si
);
   // The link clock stands still low between frames, as a real host leaves it.
   initial
   begin
      sck = 1'b0;
      si = 1'b0;
      // One deselect edge at start-up clears the device's bit counter.
      cs_n = 1'b0;
      #1 cs_n = 1'b1;
   end
   // Sends n bits MSB first; data moves while the clock is low (mode 0).
   task automatic send(input logic [15:0] w, input int n);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         si = w[15-i];
         #62.5 sck = 1'b1;
         #62.5 sck = 1'b0;
      end
      si = ~si; // A released line must not keep showing the last bit.
      #62.5 cs_n = 1'b1;
      #100;
   endtask
   // Persistent writes need an unlock frame first; dropping it tests refusal.
   task automatic put(input logic [7:0] cmd, input logic [7:0] d, input logic unlock);
      if (unlock)
         send({CMD_WRITE_UNLOCK, 8'h00}, 8);
      send({cmd, d}, 16); // Command byte, then the one data byte.
   endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the protection and configuration register block.
`timescale 1ns/1ps
module tb import fpcr_pkg::*;;
   logic clk = 1'b0, reset = 1'b0, link_sck, link_cs_n, link_si;
   logic [3:0] block_guard = 4'h0;
   logic quad_lines_enable = 1'b0, quad_command_mode = 1'b0, program_busy = 1'b0, erase_busy = 1'b0;
   logic suspend_cmd = 1'b0, resume_cmd = 1'b0, info_prog_req = 1'b0;
   logic [1:0] info_row_sel = 2'h0;
   fpcr_read_kind_e read_kind = FPCR_RD_FAST_SPI;
   logic dedicated_reset_n = 1'b1, shared_pin_n = 1'b1;
   logic [7:0] function_config, read_parameters, read_parameters_nv;
   logic write_unlocked, protect_any, info_prog_ok, shared_pin_is_reset, shared_pin_is_io3;
   logic device_reset_req, wrap_on;
   logic [5:0] protect_first, protect_last;
   logic [3:0] dummy_cycles;
   logic [6:0] wrap_len;
   logic [3:0] dflt [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6}; // Default dummy count per read kind.
   int err_count = 0, tests_run = 0;
   // The core clock runs at 125 MHz.
   always #4 clk = ~clk;
   fpcr_host_model i_fpcr_host_model (.sck(link_sck), .cs_n(link_cs_n), .si(link_si));
   fpcr_top #(.RESET_DISABLE_DEFAULT(1'b0), .HAS_DEDICATED_RESET(1'b1)) i_fpcr_top (
      .clk, .reset, .link_sck, .link_cs_n, .link_si, .block_guard, .quad_lines_enable, .quad_command_mode,
      .program_busy, .erase_busy, .suspend_cmd, .resume_cmd, .info_prog_req, .info_row_sel, .read_kind,
      .dedicated_reset_n, .shared_pin_n, .function_config, .read_parameters, .read_parameters_nv,
      .write_unlocked, .protect_any, .protect_first, .protect_last, .info_prog_ok, .shared_pin_is_reset,
      .shared_pin_is_io3, .device_reset_req, .dummy_cycles, .wrap_on, .wrap_len);
   // Inputs move only at the falling edge, clear of the sampling edge.
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One write frame, after an unlock frame when asked, then enough core cycles for the crossing to land.
   task automatic put(input logic [7:0] c, input logic [7:0] d, input logic u);
      i_fpcr_host_model.put(c, d, u);
      tick(6);
   endtask
   task automatic pulse(input logic r);
      if (r)
         resume_cmd = 1'b1;
      else
         suspend_cmd = 1'b1;
      tick(1);
      resume_cmd = 1'b0;
      suspend_cmd = 1'b0;
      tick(1);
   endtask
   // Expected {any, first, last} for a guard setting.
   function automatic logic [12:0] prot(input logic [3:0] g);
      int n;
      n = g[2:0];
      if (g[3] == 1'b0)
         prot = (n == 0) ? 13'h0 : (n == 7) ? 13'h103f : {1'b1, 6'(64 - (1 << (n - 1))), 6'h3f};
      else
         prot = (n == 7) ? 13'h0 : (n == 0) ? 13'h103f : {1'b1, 6'h00, 6'((64 >> n) - 1)};
   endfunction
   // A hang counts as a mismatch and ends the run.
   initial
   begin
      #500us;
      err_count++;
      give_verdict();
   end
   initial
   begin
      // Reset rises as an event so that the link side sees its asynchronous clear.
      #1 reset = 1'b1;
      tick(4);
      reset = 1'b0;
      tick(3);
      check(16'({function_config, read_parameters}), 16'h0000);
      check(16'({dummy_cycles, wrap_on}), 16'h0010);
      $display("test reset done");
      for (int g = 0; g < 16; g++)
      begin
         block_guard = 4'(g);
         tick(2);
         check({3'h0, protect_any, protect_first, protect_last}, 16'(prot(4'(g))));
      end
      $display("test protect done");
      put(CMD_SET_READ_PARAMS_TEMPORARY_A, 8'had, 1'b0);
      check({read_parameters, read_parameters_nv}, 16'had00);
      check(16'({dummy_cycles, wrap_on, wrap_len}), 16'h0590);
      for (int c = 0; c < 4; c++)
      begin
         put(CMD_SET_READ_PARAMS_TEMPORARY_B, 8'(4 + c), 1'b0);
         check(16'(wrap_len), 16'(8 << c));
      end
      put(CMD_SET_READ_PARAMS_TEMPORARY_B, 8'h03, 1'b0);
      check(16'({wrap_on, wrap_len}), 16'h0000);
      for (int k = 0; k < 6; k++)
      begin
         read_kind = fpcr_read_kind_e'(k);
         tick(2);
         check(16'(dummy_cycles), 16'(dflt[k]));
      end
      read_kind = FPCR_RD_FAST_SPI;
      $display("test read params done");
      i_fpcr_host_model.send({CMD_WRITE_UNLOCK, 8'h00}, 8);
      tick(6);
      check(16'(write_unlocked), 16'h0001);
      i_fpcr_host_model.send({CMD_WRITE_LOCK, 8'h00}, 8);
      tick(6);
      check(16'(write_unlocked), 16'h0000);
      put(CMD_SET_READ_PARAMS_PERSISTENT, 8'h9a, 1'b0);
      check({read_parameters, read_parameters_nv}, 16'h0300);
      put(CMD_SET_READ_PARAMS_PERSISTENT, 8'h9a, 1'b1);
      check({read_parameters, read_parameters_nv}, 16'h9a9a);
      check(16'({write_unlocked, shared_pin_is_reset, shared_pin_is_io3}), 16'h0000);
      quad_lines_enable = 1'b1;
      tick(2);
      check(16'(shared_pin_is_io3), 16'h0001);
      quad_lines_enable = 1'b0;
      quad_command_mode = 1'b1;
      tick(2);
      check(16'(shared_pin_is_io3), 16'h0001);
      quad_command_mode = 1'b0;
      dedicated_reset_n = 1'b0;
      tick(5);
      check(16'(device_reset_req), 16'h0001);
      dedicated_reset_n = 1'b1;
      put(CMD_WRITE_FUNCTION, 8'h01, 1'b1);
      check(16'({function_config, shared_pin_is_reset}), 16'h0003);
      dedicated_reset_n = 1'b0;
      tick(5);
      check(16'(device_reset_req), 16'h0000);
      quad_lines_enable = 1'b1;
      shared_pin_n = 1'b0;
      tick(5);
      check(16'({device_reset_req, shared_pin_is_reset}), 16'h0000);
      quad_lines_enable = 1'b0;
      dedicated_reset_n = 1'b1;
      tick(5);
      check(16'(device_reset_req), 16'h0001);
      shared_pin_n = 1'b1;
      put(CMD_WRITE_FUNCTION, 8'h00, 1'b1);
      check(16'(function_config), 16'h0001);
      put(CMD_WRITE_FUNCTION, 8'h1e, 1'b1);
      check(16'(function_config), 16'h0011);
      info_prog_req = 1'b1;
      #1 check(16'(info_prog_ok), 16'h0000);
      tick(1);
      info_row_sel = 2'h1;
      #1 check(16'(info_prog_ok), 16'h0001);
      tick(1);
      info_prog_req = 1'b0;
      $display("test pins and function done");
      program_busy = 1'b1;
      pulse(1'b0);
      check(16'(function_config), 16'h0015);
      pulse(1'b1);
      check(16'(function_config), 16'h0011);
      program_busy = 1'b0;
      erase_busy = 1'b1;
      pulse(1'b0);
      check(16'(function_config), 16'h0019);
      pulse(1'b1);
      check(16'(function_config), 16'h0011);
      $display("test suspend done");
      give_verdict();
   end
endmodule
